// file: sync_config.v
// multichip synchronization control and front end mode configuration
// holds the mode registers, the reference pulse source select, the per-block masks,
// and the divider, oscillator phase and ramp state that a reference pulse realigns
// assumes a synchronous byte register port and pulse inputs on the sampling clock
// assumes the pulse sources already meet setup to the sampling clock; no synchroniser here
// assumes ce low freezes every register, the read strobe and the pulse detector included
// assumes freq_word is a level that the controller changes only between hops
`timescale 1ns/1ps
`include "sync_map.vh"
module sync_config (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [8:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    input  wire        sync_reference_pulse,
    input  wire        general_purpose_pin_zero,
    input  wire [47:0] freq_word,
    output reg         term_200_ohm,
    output reg  [7:0]  freq_range,
    output reg  [7:0]  nyquist_zone,
    output reg         decim_active,
    output reg  [3:0]  decim_log2,
    output reg  [4:0]  lane_count,
    output reg         ddr_clock_en,
    output reg         divider_reset,
    output reg         phase_reset,
    output reg         ramp_reset,
    output reg  [14:0] divider_count,
    output reg  [47:0] phase_acc,
    output reg  [15:0] ramp_value
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] input_frequency_range;
    reg [7:0] sync_input_pin_select;
    reg [7:0] nyquist_zone_select;
    reg [7:0] mode_ctrl;
    reg [7:0] sync_mask;
    reg [3:0] next_log2;
    reg [4:0] next_lanes;
    wire      pulse_src;
    wire      pulse_rise;
    wire      decim_on;

    assign decim_on = mode_ctrl[`MODE_BIT_DECIM];

    // ------------------------------------------------------------
    // decimation ratio and output lane mapping
    // ------------------------------------------------------------
    // a ratio field of zero is read as the smallest ratio rather than refused
    // clamp the ratio field: 2 to 32768 is 2**1 to 2**15
    always @* begin
        next_log2 = mode_ctrl[`MODE_LOG2_LSB +: 4];
        if (next_log2 < `LOG2_MIN)
            next_log2 = `LOG2_MIN;
    end

    // lanes halve every two octaves of decimation, never below one
    always @* begin
        if (!decim_on)
            next_lanes = `BYPASS_LANES;
        else if (next_log2 <= 4'h2)
            next_lanes = 5'h08;
        else if (next_log2 <= 4'h4)
            next_lanes = 5'h04;
        else if (next_log2 <= 4'h6)
            next_lanes = 5'h02;
        else
            next_lanes = 5'h01;
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // unmapped addresses are ignored so a stray write cannot disturb the mode
    always @(posedge clk) begin
        if (rst) begin
            input_frequency_range <= `RST_FREQ_RANGE;
            sync_input_pin_select <= `RST_PIN_SELECT;
            nyquist_zone_select   <= `RST_NYQUIST_ZONE;
            mode_ctrl             <= `RST_MODE_CTRL;
            sync_mask             <= `RST_SYNC_MASK;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `ADDR_FREQ_RANGE:   input_frequency_range <= reg_wdata;
                `ADDR_PIN_SELECT:   sync_input_pin_select <= reg_wdata;
                `ADDR_NYQUIST_ZONE: nyquist_zone_select   <= reg_wdata;
                `ADDR_MODE_CTRL:    mode_ctrl             <= reg_wdata;
                `ADDR_SYNC_MASK:    sync_mask             <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // a read in the same cycle as a write to that address returns the old value
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_FREQ_RANGE:   reg_rdata <= input_frequency_range;
                    `ADDR_PIN_SELECT:   reg_rdata <= sync_input_pin_select;
                    `ADDR_NYQUIST_ZONE: reg_rdata <= nyquist_zone_select;
                    `ADDR_MODE_CTRL:    reg_rdata <= mode_ctrl;
                    `ADDR_SYNC_MASK:    reg_rdata <= sync_mask;
                    `ADDR_LANE_STATUS:  reg_rdata <= {3'h0, lane_count};
                    default:            reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // reference pulse source and edge
    // ------------------------------------------------------------
    // only the exact value selects the pin; anything else keeps the dedicated input
    assign pulse_src = (sync_input_pin_select == `PIN_SELECT_GPIO) ?
                       general_purpose_pin_zero : sync_reference_pulse;

    edge_sampler u_edge (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .pulse_in (pulse_src),
        .rise     (pulse_rise)
    );

    // ------------------------------------------------------------
    // block resets
    // ------------------------------------------------------------
    // the masks are applied after edge detection, so a mask written while a pulse
    // is in flight changes only which blocks that pulse reaches, never its length
    always @(posedge clk) begin
        if (rst) begin
            divider_reset <= 1'b0;
            phase_reset   <= 1'b0;
            ramp_reset    <= 1'b0;
        end else if (ce) begin
            // bypass latency is fixed already, so only the ramp can be realigned
            divider_reset <= pulse_rise & decim_on & sync_mask[`MASK_BIT_DIVIDER];
            phase_reset   <= pulse_rise & decim_on & sync_mask[`MASK_BIT_PHASE];
            ramp_reset    <= pulse_rise & sync_mask[`MASK_BIT_RAMP];
        end
    end

    // ------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------
    // registered copies keep every output on a flip-flop at the cost of one cycle
    always @(posedge clk) begin
        if (rst) begin
            term_200_ohm  <= 1'b0;
            freq_range    <= `RST_FREQ_RANGE;
            nyquist_zone  <= `RST_NYQUIST_ZONE;
            decim_active  <= 1'b0;
            decim_log2    <= `LOG2_MIN;
            lane_count    <= `BYPASS_LANES;
            ddr_clock_en  <= 1'b1;
        end else if (ce) begin
            term_200_ohm  <= mode_ctrl[`MODE_BIT_TERM200];
            freq_range    <= input_frequency_range;
            nyquist_zone  <= nyquist_zone_select;
            decim_active  <= decim_on;
            decim_log2    <= next_log2;
            lane_count    <= next_lanes;
            ddr_clock_en  <= ~decim_on;
        end
    end

    // ------------------------------------------------------------
    // decimation clock divider
    // ------------------------------------------------------------
    // held at zero in bypass so the first decimated sample starts from a known count
    always @(posedge clk) begin
        if (rst) begin
            divider_count <= 15'h0000;
        end else if (ce) begin
            if (divider_reset || !decim_active)
                divider_count <= 15'h0000;
            else
                divider_count <= divider_count + 15'h0001;
        end
    end

    // ------------------------------------------------------------
    // oscillator phase
    // ------------------------------------------------------------
    // the phase keeps its value in bypass; only a masked pulse or reset clears it
    always @(posedge clk) begin
        if (rst) begin
            phase_acc <= 48'h000000000000;
        end else if (ce) begin
            if (phase_reset)
                phase_acc <= 48'h000000000000;
            else if (decim_active)
                phase_acc <= phase_acc + freq_word;
        end
    end

    // ------------------------------------------------------------
    // ramp test pattern
    // ------------------------------------------------------------
    // the ramp runs in every mode, as it is the one pattern a bypass pulse realigns
    always @(posedge clk) begin
        if (rst) begin
            ramp_value <= 16'h0000;
        end else if (ce) begin
            if (ramp_reset)
                ramp_value <= 16'h0000;
            else
                ramp_value <= ramp_value + 16'h0001;
        end
    end
endmodule

// file: sync_map.vh
// constants for the multichip sync and mode configuration block
// assumes a byte-wide register port with a 9-bit address, clocked by the sampling clock
`ifndef SYNC_MAP_VH
`define SYNC_MAP_VH
`define ADDR_FREQ_RANGE    9'h132
`define ADDR_PIN_SELECT    9'h146
`define ADDR_NYQUIST_ZONE  9'h16b
`define ADDR_MODE_CTRL     9'h150
`define ADDR_SYNC_MASK     9'h151
`define ADDR_LANE_STATUS   9'h152
`define RST_FREQ_RANGE     8'h00
`define RST_PIN_SELECT     8'h01
`define RST_NYQUIST_ZONE   8'h00
`define RST_MODE_CTRL      8'h00
`define RST_SYNC_MASK      8'h07
`define PIN_SELECT_GPIO    8'h00
`define MODE_BIT_DECIM     0
`define MODE_BIT_TERM200   1
`define MODE_LOG2_LSB      2
`define MASK_BIT_DIVIDER   0
`define MASK_BIT_PHASE     1
`define MASK_BIT_RAMP      2
`define LOG2_MIN           4'h1
`define LOG2_MAX           4'hf
`define BYPASS_LANES       5'h10
`define FREQ_WORD_WIDTH    48
`endif

// file: edge_sampler.v
// rising edge detector for the chosen reference pulse source
// assumes the source is already synchronous to the sampling clock
`timescale 1ns/1ps
module edge_sampler (
    input  wire clk,
    input  wire rst,
    input  wire ce,
    input  wire pulse_in,
    output reg  rise
);
    reg sampled;
    reg prev;

    always @(posedge clk) begin
        if (rst) begin
            sampled <= 1'b0;
            prev    <= 1'b0;
            rise    <= 1'b0;
        end else if (ce) begin
            sampled <= pulse_in;
            prev    <= sampled;
            rise    <= sampled & ~prev;
        end
    end
endmodule

// file: sync_config_properties.sv
// assertions on the ports of the sync and mode block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module sync_config_properties (
    input wire        clk,
    input wire        rst,
    input wire        ce,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire        reg_rvalid,
    input wire        term_200_ohm,
    input wire        decim_active,
    input wire        ddr_clock_en,
    input wire        sync_reference_pulse,
    input wire        general_purpose_pin_zero,
    input wire        divider_reset,
    input wire        phase_reset,
    input wire        ramp_reset,
    input wire [8:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  freq_range,
    input wire [7:0]  nyquist_zone,
    input wire [4:0]  lane_count,
    input wire [14:0] divider_count,
    input wire [47:0] phase_acc,
    input wire [15:0] ramp_value
);
// ----------------------------------------
// properties
// ----------------------------------------
default clocking @(posedge clk); endclocking
default disable iff (rst);
sequence s_ramp_done;
    ramp_reset ##1 (!ramp_reset && ramp_value == 16'h0000);
endsequence
// the register is written at the first edge and copied to the output at the second
a_term_follows_write: assert property (ce && reg_wr && reg_addr == 9'h150 |-> ##2 term_200_ohm == $past(reg_wdata[1], 2))
    else $error("termination does not follow mode write");
a_range_write: assert property (ce && reg_wr && reg_addr == 9'h132 |-> ##2 freq_range == $past(reg_wdata, 2))
    else $error("frequency range not updated");
a_zone_write: assert property (ce && reg_wr && reg_addr == 9'h16b |-> ##2 nyquist_zone == $past(reg_wdata, 2))
    else $error("nyquist zone not updated");
a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
a_bypass_parallel: assert property (!decim_active |-> lane_count == 5'h10 && ddr_clock_en)
    else $error("bypass output not parallel");
a_decim_serial: assert property (decim_active |-> lane_count < 5'h10 && !ddr_clock_en)
    else $error("decimation output not serial");
a_bypass_ramp_only: assert property (!decim_active && !$past(decim_active) |-> !divider_reset && !phase_reset)
    else $error("decimation reset in bypass");
a_pulse_latency: assert property (ramp_reset || phase_reset || divider_reset |->
    ($past(sync_reference_pulse, 3) && !$past(sync_reference_pulse, 4))
    || ($past(general_purpose_pin_zero, 3) && !$past(general_purpose_pin_zero, 4)))
    else $error("reset pulse without source rise");
a_ramp_once: assert property (ramp_reset |-> s_ramp_done)
    else $error("ramp reset not single or ramp not cleared");
a_divider_cleared: assert property (divider_reset |=> divider_count == 15'h0000)
    else $error("divider not cleared");
a_phase_cleared: assert property (phase_reset |=> phase_acc == 48'h0 && !phase_reset)
    else $error("phase not cleared");
endmodule
bind sync_config sync_config_properties u_sync_config_properties (.*);

// file: sync_pulse_source.sv
// model of the external reference pulse generator
// assumes go is driven by the bench with non-blocking updates
`timescale 1ns/1ps
module sync_pulse_source (
    input  wire clk,
    input  wire go,
    input  wire use_gpio,
    output reg  sref = 1'b0,
    output reg  gpio_pin = 1'b0
);
// launched on the falling edge so the rising sampling edge sits mid-pulse
always @(negedge clk) begin
    sref <= go & !use_gpio;
    gpio_pin <= go & use_gpio;
end
endmodule

// file: tb_sync_config.sv
// self-checking bench for sync_config
// assumes the pulse source model and the checker compile alongside
`timescale 1ns/1ps
module tb_sync_config;
reg        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, go = 0, use_gpio = 0;
reg  [8:0] reg_addr = 9'h000;
reg  [7:0] reg_wdata = 8'h00;
reg  [2:0] seen;
wire [7:0] reg_rdata, freq_range, nyquist_zone;
wire       reg_rvalid, term_200_ohm, decim_active, ddr_clock_en, divider_reset, phase_reset, ramp_reset, sref, gpin;
wire [4:0] lane_count;
wire [3:0] decim_log2;
integer    n_errors = 0, n_compared = 0;
initial forever #2 clk = ~clk;
sync_pulse_source u_sync_pulse_source (.clk(clk), .go(go), .use_gpio(use_gpio), .sref(sref), .gpio_pin(gpin));
sync_config u_sync_config (.clk(clk), .rst(rst), .ce(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sync_reference_pulse(sref),
    .general_purpose_pin_zero(gpin), .freq_word(48'h3), .term_200_ohm(term_200_ohm), .freq_range(freq_range),
    .nyquist_zone(nyquist_zone), .decim_active(decim_active), .decim_log2(decim_log2), .lane_count(lane_count),
    .ddr_clock_en(ddr_clock_en), .divider_reset(divider_reset), .phase_reset(phase_reset), .ramp_reset(ramp_reset),
    .divider_count(), .phase_acc(), .ramp_value());
task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
        end
    end
endtask
task wr(input [8:0] a, input [7:0] d);
    begin
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    end
endtask
task rd(input [8:0] a, input [7:0] exp);
    begin
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk("rdata", exp, reg_rdata);
    end
endtask
// fixed window: the resets are due three edges after the source rises
task pulse(input g, input [2:0] exp);
    begin
        @(negedge clk);
        use_gpio <= g;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        seen = 3'b000;
        repeat (8) begin
            @(negedge clk);
            seen = seen | {ramp_reset, phase_reset, divider_reset};
        end
        chk("resets", {5'h00, exp}, {5'h00, seen});
    end
endtask
task wrap_up;
    begin
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
endtask
initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd(9'h132, 8'h00);
    rd(9'h146, 8'h01);
    rd(9'h16b, 8'h00);
    rd(9'h151, 8'h07);
    chk("term", 8'h00, {7'h00, term_200_ohm});
    chk("lanes", 8'h10, {3'h0, lane_count});
    $display("test reset_values done");
    wr(9'h132, 8'h5a);
    wr(9'h16b, 8'h02);
    rd(9'h132, 8'h5a);
    chk("zone", 8'h02, nyquist_zone);
    rd(9'h1ff, 8'h00);
    pulse(1'b0, 3'b100);
    $display("test bypass done");
    wr(9'h150, 8'h0f);
    chk("term", 8'h01, {7'h00, term_200_ohm});
    chk("lanes", 8'h04, {3'h0, lane_count});
    chk("log2", 8'h03, {4'h0, decim_log2});
    wr(9'h151, 8'h02);
    pulse(1'b0, 3'b010);
    wr(9'h151, 8'h07);
    pulse(1'b0, 3'b111);
    wr(9'h150, 8'h03);
    chk("log2", 8'h01, {4'h0, decim_log2});
    chk("lanes", 8'h08, {3'h0, lane_count});
    rd(9'h152, 8'h08);
    $display("test decimation done");
    wr(9'h146, 8'h00);
    pulse(1'b0, 3'b000);
    pulse(1'b1, 3'b111);
    $display("test gpio_source done");
    wrap_up;
end
initial begin
    #100000;
    n_errors = n_errors + 1;
    wrap_up;
end
endmodule
